// *** nsc_params.svh ***
// Offsets, field positions, reset values and load-word layout of the NVM config block
`ifndef NSC_PARAMS_SVH
`define NSC_PARAMS_SVH
`define NSC_CTRL_OFS      32'h0000_0000
`define NSC_AW_BIT        10
`define NSC_CAP_LSB       11
`define NSC_CAP_MSB       14
`define NSC_ABC_LSB       15
`define NSC_ABC_MSB       16
`define NSC_AUPD_BIT      20
`define NSC_KIND_LSB      23
`define NSC_KIND_MSB      24
`define NSC_RSVD_MASK     32'hfe6e_0000
`define NSC_CAP_RST       4'h2
`define NSC_ABC_RST       2'h0
`define NSC_KIND_RST      2'h0
`define NSC_ABC_ONE       2'h1
`define NSC_ABC_TWO       2'h2
`define NSC_ABC_THREE     2'h3
`define NSC_CAP_TWO_BYTE  4'h3
`define NSC_CAP_UNIT      24'h00_0080
`define NSC_CFG_WORD      8'h0f
`define NSC_SIG_WORD      8'h12
`define NSC_CFG_CAP_LSB   0
`define NSC_CFG_CAP_MSB   3
`define NSC_CFG_KIND_LSB  4
`define NSC_CFG_KIND_MSB  5
`define NSC_SIG_LSB       14
`define NSC_SIG_MSB       15
`define NSC_SIG_VALID     2'h1
`define NSC_RESP_OKAY     2'h0
`define NSC_RESP_SLVERR   2'h2
`endif

// *** nsc_pkg.sv ***
// Types shared by the NVM config block and its loader
package nsc_pkg;
  // Loader sequence, one-hot
  typedef enum logic [3:0] {
    NSC_LD_IDLE = 4'b0001,
    NSC_LD_CFG  = 4'b0010,
    NSC_LD_SIG  = 4'b0100,
    NSC_LD_DONE = 4'b1000
  } nsc_ld_state_e;
  typedef logic [1:0] nsc_abc_t;  // Address byte count encoding
  typedef logic [3:0] nsc_cap_t;  // Capacity exponent
endpackage : nsc_pkg

// *** nsc_load_if.sv ***
// Carrier between the register core and the NVM word loader
`timescale 1ns/1ps
interface nsc_load_if;
  logic              rd_req;     // Word read request to NVM fetch port
  logic [7:0]        rd_addr;    // Word address requested
  logic              rd_valid;   // Fetched word present
  logic [15:0]       rd_data;    // Fetched word
  logic              strap;      // Kind strap, 1 = flash
  logic              is_flash;   // Strap as captured
  nsc_pkg::nsc_cap_t cap_code;   // Loaded capacity exponent
  logic [1:0]        kind_code;  // Loaded kind code
  logic              sig_ok;     // Signature found in EEPROM
  logic              done;       // Load finished
  modport loader (input rd_valid, rd_data, strap,
                  output rd_req, rd_addr, is_flash, cap_code, kind_code, sig_ok, done);
  modport core (output rd_valid, rd_data, strap,
                input rd_req, rd_addr, is_flash, cap_code, kind_code, sig_ok, done);
endinterface : nsc_load_if

// *** nsc_loader.sv ***
// Power-on loader: captures the kind strap and fetches the config word and, on an EEPROM only, the signature word
`timescale 1ns/1ps
`include "nsc_params.svh"
module nsc_loader (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  nsc_load_if.loader  ld
);
  nsc_pkg::nsc_ld_state_e st_q, st_d;      // Sequence state
  logic                   req_q, req_d;    // Outstanding fetch
  logic [7:0]             addr_q, addr_d;  // Fetch word address
  logic                   fl_q, fl_d;      // Captured strap
  nsc_pkg::nsc_cap_t      cap_q, cap_d;    // Capacity exponent
  logic [1:0]             kind_q, kind_d;  // Kind code
  logic                   sig_q, sig_d;    // Signature valid

  // Next-state: strap is caught one edge after release, never under reset
  always_comb begin
    st_d = st_q;
    req_d = req_q;
    addr_d = addr_q;
    fl_d = fl_q;
    cap_d = cap_q;
    kind_d = kind_q;
    sig_d = sig_q;
    case (st_q)
      nsc_pkg::NSC_LD_IDLE: begin
        fl_d = ld.strap;
        req_d = 1'b1;
        addr_d = `NSC_CFG_WORD;
        st_d = nsc_pkg::NSC_LD_CFG;
      end
      nsc_pkg::NSC_LD_CFG: begin
        if (ld.rd_valid) begin
          cap_d = ld.rd_data[`NSC_CFG_CAP_MSB:`NSC_CFG_CAP_LSB];
          kind_d = ld.rd_data[`NSC_CFG_KIND_MSB:`NSC_CFG_KIND_LSB];
          // Flash carries no EEPROM signature, skip its fetch
          if (fl_q) begin
            req_d = 1'b0;
            st_d = nsc_pkg::NSC_LD_DONE;
          end else begin
            addr_d = `NSC_SIG_WORD;
            st_d = nsc_pkg::NSC_LD_SIG;
          end
        end
      end
      nsc_pkg::NSC_LD_SIG: begin
        if (ld.rd_valid) begin
          sig_d = (ld.rd_data[`NSC_SIG_MSB:`NSC_SIG_LSB] == `NSC_SIG_VALID);
          req_d = 1'b0;
          st_d = nsc_pkg::NSC_LD_DONE;
        end
      end
      nsc_pkg::NSC_LD_DONE: st_d = st_q;  // Held until next reset
      default: st_d = nsc_pkg::NSC_LD_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= nsc_pkg::NSC_LD_IDLE;
      req_q <= 1'b0;
      addr_q <= 8'h00;
      fl_q <= 1'b0;
      cap_q <= `NSC_CAP_RST;
      kind_q <= `NSC_KIND_RST;
      sig_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      addr_q <= addr_d;
      fl_q <= fl_d;
      cap_q <= cap_d;
      kind_q <= kind_d;
      sig_q <= sig_d;
    end
  end

  assign ld.rd_req = req_q;
  assign ld.rd_addr = addr_q;
  assign ld.is_flash = fl_q;
  assign ld.cap_code = cap_q;
  assign ld.kind_code = kind_q;
  assign ld.sig_ok = sig_q;
  // One-hot done bit taken as is, so the done output comes straight from a flop
  assign ld.done = st_q[3];

  // Signature fetch only follows the config word on an EEPROM
  a_sig_after_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == nsc_pkg::NSC_LD_CFG && ld.rd_valid && !fl_q)
      |=> (st_q == nsc_pkg::NSC_LD_SIG && addr_q == `NSC_SIG_WORD && req_q))
    else $error("signature fetch did not follow config word");
endmodule : nsc_loader

// *** nsc_cfg.sv ***
// NVM size, type and address-width config fields behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "nsc_params.svh"
module nsc_cfg (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        nvm_kind_strap,
  output logic             nvm_rd_req,
  output logic [7:0]       nvm_rd_addr,
  input  wire logic        nvm_rd_valid,
  input  wire logic [15:0] nvm_rd_data,
  output logic             nvm_load_done,
  input  wire logic        flash_write_cycle,
  input  wire logic        flash_timer_expired,
  output logic             flash_update_req,
  output logic             eeprom_addr_width_sel,
  output logic [1:0]       nvm_addr_byte_count,
  output logic [23:0]      nvm_capacity_bytes
);
  nsc_load_if ld ();  // Loader carrier

  // Byte capacity from exponent
  function automatic logic [23:0] cap_bytes(input nsc_pkg::nsc_cap_t c);
    cap_bytes = `NSC_CAP_UNIT << c;
  endfunction : cap_bytes

  // Address decode, shared by both channels
  function automatic logic hit(input logic [31:0] a);
    hit = (a[31:2] == 30'(`NSC_CTRL_OFS >> 2));  // Word index, byte lanes dropped
  endfunction : hit

  nsc_loader nsc_loader_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ld      (ld)
  );
  assign ld.strap = nvm_kind_strap;
  assign ld.rd_valid = nvm_rd_valid;
  assign ld.rd_data = nvm_rd_data;

  logic                 aw_have_q, aw_have_d;  // Write address held
  logic [31:0]          aw_addr_q, aw_addr_d;  // Held write address
  logic                 w_have_q, w_have_d;    // Write data held
  logic [31:0]          w_data_q, w_data_d;    // Held write data
  logic [3:0]           w_strb_q, w_strb_d;    // Held byte strobes
  logic                 awr_q, awr_d;          // awready
  logic                 wr_q, wr_d;            // wready
  logic                 bv_q, bv_d;            // bvalid
  logic [1:0]           br_q, br_d;            // bresp
  logic                 arr_q, arr_d;          // arready
  logic                 rv_q, rv_d;            // rvalid
  logic [31:0]          rd_q, rd_d;            // rdata
  logic [1:0]           rr_q, rr_d;            // rresp
  logic                 aw_sel_q, aw_sel_d;    // Address-width select
  nsc_pkg::nsc_abc_t    abc_q, abc_d;          // Address byte count
  logic                 aupd_q, aupd_d;        // Autonomous update enable
  logic                 upd_q, upd_d;          // Update request pulse
  logic                 done_q;                // Load seen finished
  logic [23:0]          capb_q, capb_d;        // Capacity in bytes
  logic                 do_wr;                 // Write commits this cycle
  logic [31:0]          rval;                  // Register read image

  // Read image: loaded fields live, reserved bits zero
  always_comb begin
    rval = 32'h0000_0000;
    rval[`NSC_AW_BIT] = aw_sel_q;
    rval[`NSC_CAP_MSB:`NSC_CAP_LSB] = ld.cap_code;
    rval[`NSC_ABC_MSB:`NSC_ABC_LSB] = abc_q;
    rval[`NSC_AUPD_BIT] = aupd_q;
    rval[`NSC_KIND_MSB:`NSC_KIND_LSB] = ld.kind_code;
  end

  // Bus channels: address and data taken in either order, one write at a time
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    do_wr = 1'b0;
    if (s_axi_awvalid && awr_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    // Response only after both halves
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end else if (aw_have_d && w_have_d && !bv_q) begin
      do_wr = hit(aw_addr_d);
      bv_d = 1'b1;
      br_d = hit(aw_addr_d) ? `NSC_RESP_OKAY : `NSC_RESP_SLVERR;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    // Reads: unmapped address answers zero with an error
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end else if (s_axi_arvalid && arr_q) begin
      rv_d = 1'b1;
      rd_d = hit(s_axi_araddr) ? rval : 32'h0000_0000;
      rr_d = hit(s_axi_araddr) ? `NSC_RESP_OKAY : `NSC_RESP_SLVERR;
    end
    awr_d = !aw_have_d && !bv_d;
    wr_d = !w_have_d && !bv_d;
    arr_d = !rv_d;
  end

  // Field next values; loaded fields are not software writable
  always_comb begin
    aw_sel_d = aw_sel_q;
    abc_d = abc_q;
    aupd_d = aupd_q;
    if (do_wr && w_strb_d[1]) begin
      aw_sel_d = w_data_d[`NSC_AW_BIT];
    end
    if (do_wr && w_strb_d[2]) begin
      aupd_d = w_data_d[`NSC_AUPD_BIT];
    end
    // Byte count set once loading ends; only an empty EEPROM lets software change it later
    if (ld.done && !done_q) begin
      if (ld.is_flash) begin
        abc_d = `NSC_ABC_THREE;
      end else if (ld.sig_ok && ld.cap_code >= `NSC_CAP_TWO_BYTE) begin
        abc_d = `NSC_ABC_TWO;
      end else begin
        abc_d = `NSC_ABC_ONE;
      end
    end else if (do_wr && done_q && !ld.is_flash && !ld.sig_ok
                 && (w_strb_d[1] || w_strb_d[2])) begin
      // Empty EEPROM only: lets software reach a blank part
      abc_d = w_data_d[`NSC_ABC_MSB:`NSC_ABC_LSB];
    end
    upd_d = aupd_q && (flash_write_cycle || flash_timer_expired);
    capb_d = cap_bytes(ld.cap_code);
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= `NSC_RESP_OKAY;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= `NSC_RESP_OKAY;
      aw_sel_q <= 1'b0;
      abc_q <= `NSC_ABC_RST;
      aupd_q <= 1'b0;
      upd_q <= 1'b0;
      done_q <= 1'b0;
      capb_q <= 24'h00_0000;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      bv_q <= bv_d;
      br_q <= br_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      aw_sel_q <= aw_sel_d;
      abc_q <= abc_d;
      aupd_q <= aupd_d;
      upd_q <= upd_d;
      done_q <= ld.done;
      capb_q <= capb_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  assign nvm_rd_req = ld.rd_req;
  assign nvm_rd_addr = ld.rd_addr;
  assign nvm_load_done = ld.done;
  assign flash_update_req = upd_q;
  assign eeprom_addr_width_sel = aw_sel_q;
  assign nvm_addr_byte_count = abc_q;
  assign nvm_capacity_bytes = capb_q;

  a_reset_values: assert property (@(posedge aclk)
    !aresetn |=> (!eeprom_addr_width_sel && !aupd_q && ld.cap_code == `NSC_CAP_RST))
    else $error("reset values wrong");
  a_cap_bytes: assert property (@(posedge aclk) disable iff (!aresetn)
    ld.done |=> nvm_capacity_bytes == (`NSC_CAP_UNIT << $past(ld.cap_code)))
    else $error("capacity bytes mismatch");
  a_flash_three: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld.done && !done_q && ld.is_flash) |=> nvm_addr_byte_count == `NSC_ABC_THREE)
    else $error("flash byte count not three");
  a_eeprom_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld.done && !done_q && !ld.is_flash && ld.sig_ok)
      |=> nvm_addr_byte_count == ((ld.cap_code >= `NSC_CAP_TWO_BYTE) ? 2'h2 : 2'h1))
    else $error("signed eeprom byte count wrong");
  a_count_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_q && (ld.is_flash || ld.sig_ok)) |=> $stable(nvm_addr_byte_count))
    else $error("byte count changed on signed part");
  a_update_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (flash_write_cycle || flash_timer_expired) |=> (flash_update_req == $past(aupd_q)))
    else $error("update request not tied to enable");
  a_kind_held: assert property (@(posedge aclk) disable iff (!aresetn)
    done_q |=> ($stable(ld.kind_code) && $stable(ld.cap_code)))
    else $error("loaded field changed");
  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata & `NSC_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved bits not zero");
  a_kind_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr) && done_q)
      |=> s_axi_rdata[24:23] == ld.kind_code)
    else $error("kind code readback wrong");
endmodule : nsc_cfg

// *** nsc_nvm_model.sv ***
// Behavioural model of the serial NVM part that answers the word fetch port
`timescale 1ns/1ps
module nsc_nvm_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_addr,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  input  wire logic [15:0] cfg_word,
  input  wire logic [15:0] sig_word,
  input  wire logic [7:0]  delay
);
  logic [7:0] cnt_q;  // Cycles the current request has waited

  // Answer after delay cycles; data toggles when not valid so a stale word never looks good
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 8'h00;
      rd_valid <= 1'b0;
      rd_data  <= 16'h5a5a;
    end else if (rd_valid) begin
      // One-cycle word; loader moves on at this same edge
      cnt_q    <= 8'h00;
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
    end else if (rd_req && cnt_q >= delay) begin
      rd_valid <= 1'b1;
      cnt_q    <= 8'h00;
      if (rd_addr == 8'h0f) begin
        rd_data <= cfg_word;
      end else if (rd_addr == 8'h12) begin
        rd_data <= sig_word;
      end else begin
        rd_data <= ~rd_data;  // No such word in this part
      end
    end else begin
      cnt_q   <= rd_req ? cnt_q + 8'h01 : 8'h00;
      rd_data <= ~rd_data;
    end
  end
endmodule : nsc_nvm_model

// *** nsc_cfg_tb_top.sv ***
// Self-checking bench for the NVM config register block
`timescale 1ns/1ps
module nsc_cfg_tb_top;
  logic        aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, abc;
  logic        strap, rd_req, rd_valid, load_done, wr_cyc, tmr_exp, upd_req, aw_sel;
  logic [7:0]  rd_addr, delay;
  logic [15:0] rd_data, cfg_word, sig_word;
  logic [23:0] cap_bytes;
  logic [31:0] rv;
  logic [1:0]  rs;
  int          mismatches, cmp_count;

  nsc_cfg nsc_cfg_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .nvm_kind_strap(strap), .nvm_rd_req(rd_req), .nvm_rd_addr(rd_addr),
    .nvm_rd_valid(rd_valid), .nvm_rd_data(rd_data), .nvm_load_done(load_done),
    .flash_write_cycle(wr_cyc), .flash_timer_expired(tmr_exp), .flash_update_req(upd_req),
    .eeprom_addr_width_sel(aw_sel), .nvm_addr_byte_count(abc),
    .nvm_capacity_bytes(cap_bytes));

  nsc_nvm_model nsc_nvm_model_i (.aclk(aclk), .aresetn(aresetn), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .cfg_word(cfg_word),
    .sig_word(sig_word), .delay(delay));

  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Reset with a given strap and NVM contents; reset held two cycles
  task automatic rst(input logic s, input logic [15:0] c, input logic [15:0] g,
                     input logic [7:0] d);
    @(posedge aclk);
    aresetn  <= 1'b0;
    strap    <= s;
    cfg_word <= c;
    sig_word <= g;
    delay    <= d;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  // Wait until the loader is done and the byte count has settled
  task automatic wait_load();
    while (load_done !== 1'b1) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask : wait_load

  // AXI4-Lite write; address and data offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // AXI4-Lite read
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // One trigger cycle on write or timer; request must follow one cycle later iff enabled
  task automatic trig(input logic tmr, input logic en);
    @(posedge aclk);
    wr_cyc  <= ~tmr;
    tmr_exp <= tmr;
    @(posedge aclk);
    wr_cyc  <= 1'b0;
    tmr_exp <= 1'b0;
    #1 chk("update_req", {31'h0, en}, {31'h0, upd_req});
    @(posedge aclk);
    #1 chk("update_idle", 32'h0, {31'h0, upd_req});
    // Back on an edge so the next task drives at the clock
    @(posedge aclk);
  endtask : trig

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // Watchdog: the tests need a few hundred cycles
  initial begin
    #2_000_000;
    mismatches++;
    test_done();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wr_cyc, tmr_exp} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0;
    strap = 1'b0;
    {cfg_word, sig_word} = '0;
    delay = 8'd40;
    cmp_count = 0;
    mismatches = 0;
    // Signed EEPROM, slow part: reset view, load, software writes, triggers
    rst(1'b0, 16'h0025, 16'h4000, 8'd40);
    axi_rd(32'h0, rv, rs);
    chk("reset_value", 32'h0000_1000, rv);
    wait_load();
    axi_rd(32'h0, rv, rs);
    chk("loaded_value", 32'h0101_2800, rv);
    chk("read_resp", 32'h0, {30'h0, rs});
    chk("cap_bytes", 32'h0000_1000, {8'h0, cap_bytes});
    chk("byte_count", 32'h2, {30'h0, abc});
    axi_wr(32'h0, 32'hffff_ffff, 4'hf, rs);
    chk("write_resp", 32'h0, {30'h0, rs});
    axi_rd(32'h0, rv, rs);
    chk("after_ones", 32'h0111_2c00, rv);
    chk("width_sel", 32'h1, {31'h0, aw_sel});
    trig(1'b0, 1'b1);
    trig(1'b1, 1'b1);
    axi_wr(32'h0, 32'h0, 4'hf, rs);
    trig(1'b0, 1'b0);
    trig(1'b1, 1'b0);
    axi_rd(32'h0, rv, rs);
    chk("after_zero", 32'h0101_2800, rv);
    axi_wr(32'h40, 32'hffff_ffff, 4'hf, rs);
    chk("unmapped_bresp", 32'h2, {30'h0, rs});
    axi_rd(32'h40, rv, rs);
    chk("unmapped_rresp", 32'h2, {30'h0, rs});
    chk("unmapped_rdata", 32'h0, rv);
    $display("test signed eeprom done");
    // Empty EEPROM: software may set the byte count
    rst(1'b0, 16'h0003, 16'h0000, 8'd1);
    wait_load();
    axi_rd(32'h0, rv, rs);
    chk("empty_value", 32'h0000_9800, rv);
    chk("empty_bytes", 32'h0000_0400, {8'h0, cap_bytes});
    axi_wr(32'h0, 32'h0001_8000, 4'h6, rs);
    axi_rd(32'h0, rv, rs);
    chk("empty_sw_write", 32'h0001_9800, rv);
    chk("empty_count", 32'h3, {30'h0, abc});
    $display("test empty eeprom done");
    // Flash strap: three address bytes, software write has no effect
    rst(1'b1, 16'h0031, 16'h4000, 8'd3);
    wait_load();
    axi_rd(32'h0, rv, rs);
    chk("flash_value", 32'h0181_8800, rv);
    axi_wr(32'h0, 32'h0000_8000, 4'hf, rs);
    axi_rd(32'h0, rv, rs);
    chk("flash_sw_write", 32'h0181_8800, rv);
    chk("flash_bytes", 32'h0000_0100, {8'h0, cap_bytes});
    $display("test flash strap done");
    test_done();
  end
endmodule : nsc_cfg_tb_top
